// *** flow_io_pkg.sv ***
package flow_io_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_INPUT_CFG = 8'h00;
    localparam logic [7:0] OFS_THRESHOLD = 8'h04;
    localparam logic [7:0] OFS_RATE_SCALE = 8'h08;
    localparam logic [7:0] OFS_TOTAL_SCALE = 8'h0c;
    localparam logic [7:0] OFS_AUX_LOW = 8'h10;
    localparam logic [7:0] OFS_AUX_HIGH = 8'h14;
    localparam logic [7:0] OFS_RETX_LOW = 8'h18;
    localparam logic [7:0] OFS_RETX_HIGH = 8'h1c;
    localparam logic [7:0] OFS_RETX_FAIL = 8'h20;
    localparam logic [7:0] OFS_PULSE_CFG = 8'h24;
    localparam logic [7:0] OFS_PULSE_VOL = 8'h28;
    localparam logic [7:0] OFS_PULSE_TIME = 8'h2c;
    localparam logic [7:0] OFS_RELAY_ROUTE = 8'h30;
    localparam logic [7:0] OFS_RATE = 8'h34;
    localparam logic [7:0] OFS_TOTAL = 8'h38;
    localparam logic [7:0] OFS_AUX = 8'h3c;
    localparam logic [7:0] OFS_STATUS = 8'h40;
    localparam logic [7:0] OFS_CFG_RESET = 8'h44;

    // input type codes
    localparam logic [2:0] IN_ANALOG = 3'h0;
    localparam logic [2:0] IN_NPN = 3'h1;
    localparam logic [2:0] IN_PNP = 3'h2;
    localparam logic [2:0] IN_REED = 3'h3;
    localparam logic [2:0] IN_COIL = 3'h4;

    // rate time base codes
    localparam logic [1:0] TB_SEC = 2'h0;
    localparam logic [1:0] TB_MIN = 2'h1;
    localparam logic [1:0] TB_HOUR = 2'h2;
    localparam logic [1:0] TB_DAY = 2'h3;

    // pulse output modes
    localparam logic [1:0] PM_OFF = 2'h0;
    localparam logic [1:0] PM_VOLUME = 2'h1;
    localparam logic [1:0] PM_FREQ = 2'h2;

    // relay route codes: 0 off, 1..4 alarm
    localparam logic [2:0] ROUTE_OFF = 3'h0;
    localparam logic [11:0] ROUTE_DEFAULT = 12'h8d1;

    // sample tick: one measurement window per 1 ms
    localparam int CLK_HZ = 40000000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;

    // fixed point: 12-bit analog fraction, 4 mA = 0x333, 20 mA = 0xfff
    localparam logic [11:0] ADC_LOW = 12'h333;
    localparam logic [11:0] ADC_SPAN = 12'hccc;
    localparam logic [15:0] DAC_LOW = 16'h3333;
    localparam logic [15:0] DAC_SPAN = 16'hcccc;

    // input configuration word layout
    typedef struct packed {
        logic [20:0] unused;
        logic [3:0] smoothing;
        logic sqrt_en;
        logic [1:0] timebase;
        logic aux_en;
        logic [2:0] in_type;
    } input_cfg_t;

    typedef struct packed {
        logic [29:0] unused;
        logic [1:0] mode;
    } pulse_cfg_t;

    typedef enum logic [2:0] {
        PS_IDLE = 3'b001,
        PS_HOLD = 3'b010,
        PS_FREQ = 3'b100
    } pulse_state_t;
endpackage

// *** flow_io_setup.sv ***
// Functional notes
// - flow below threshold reads zero, no totalizing
// - aux analog only when flow input digital
// - aux scaled low..high, settable only enabled; writes also accepted while flow analog
// - time base from unit setting selector
// - rate scaled by pulses-per-volume, digital only
// - total scaled by separate pulses-per-volume factor
// - square root option on analog within range
// - analog filter, only when analog enabled
// - five flow input types supported
// - retransmit low/high map to output span
// - equal retransmit limits switch output off; input failure still turns it on at the error value
// - input failure drives programmed error value
// - pulse output off, volumetric or frequency
// - volumetric pulse per programmed volume increment
// - volumetric pulse held programmed duration
// - frequency output is input divided
// - each relay off or alarm one to four
// - several relays may share one alarm
// - configuration reset routes relay n to alarm n
module flow_io_setup (
    input wire logic I_MCLK, // system clock 40 MHz
    input wire logic I_RST, // synchronous reset, high
    input wire logic I_HSEL, // ahb slave select
    input wire logic [7:0] I_HADDR, // ahb address
    input wire logic [1:0] I_HTRANS, // ahb transfer type
    input wire logic I_HWRITE, // ahb write
    input wire logic [2:0] I_HSIZE, // ahb size
    input wire logic [31:0] I_HWDATA, // ahb write data
    input wire logic I_HREADY, // ahb bus ready
    input wire logic I_PULSE_IN, // digital flow pulse
    input wire logic [11:0] I_ANALOG, // analog input sample
    input wire logic I_IN_FAIL, // input failure detected
    input wire logic [3:0] I_ALARM, // alarm states one..four
    output logic [31:0] O_HRDATA, // ahb read data
    output logic O_HREADYOUT, // ahb ready out
    output logic O_HRESP, // ahb response
    output logic [15:0] O_RETX, // current output code
    output logic O_RETX_EN, // current output on
    output logic O_PULSE_OUT, // isolated pulse output
    output logic [3:0] O_RELAY // relay drives
);
    ////////////////////////////////////////////////////////////////////
    // registers
    flow_io_pkg::input_cfg_t in_cfg_reg;
    flow_io_pkg::pulse_cfg_t pulse_cfg_reg;
    logic [31:0] threshold_reg, rate_scale_reg, total_scale_reg;
    logic [31:0] aux_low_reg, aux_high_reg;
    logic [31:0] retx_low_reg, retx_high_reg;
    logic [15:0] retx_fail_reg;
    logic [31:0] pulse_vol_reg, pulse_time_reg, freq_div_reg;
    logic [11:0] route_reg;
    logic [31:0] rate_reg, total_reg, aux_reg;
    logic [31:0] total_acc_reg, vol_acc_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] tick_cnt_reg, pulse_cnt_reg, hold_cnt_reg, div_cnt_reg;
    logic [2:0] pin_sync_reg;
    logic [15:0] filt_reg;
    flow_io_pkg::pulse_state_t pstate_reg;
    logic [31:0] scaled_next, rate_next, flow_add, vol_add;
    logic analog_flow, aux_ok, pulse_edge, pin_change, tick;

    // scale x*num/den with saturation-free 64-bit product
    function automatic logic [31:0] scale(input logic [31:0] x,
            input logic [31:0] num, input logic [31:0] den);
        logic [63:0] p;
        p = 64'(x) * 64'(num);
        scale = (den == 32'h0) ? 32'h0 : 32'(p / 64'(den));
    endfunction

    // map fraction f (0..ffff) onto lo..hi range
    function automatic logic [31:0] span(input logic [15:0] f,
            input logic [31:0] lo, input logic [31:0] hi);
        logic [63:0] d;
        d = 64'(hi - lo) * 64'(f);
        span = lo + 32'(d >> 16);
    endfunction

    assign analog_flow = (in_cfg_reg.in_type == flow_io_pkg::IN_ANALOG);
    // aux only legal while the flow input is digital
    assign aux_ok = in_cfg_reg.aux_en && !analog_flow;
    assign tick = (tick_cnt_reg == 32'(flow_io_pkg::TICK_CYC - 1));

    ////////////////////////////////////////////////////////////////////
    // ahb slave: zero wait states, write data taken in data phase
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE;
            wr_addr_reg <= I_HADDR;
        end
    end

    // read data mux, registered at address phase
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_HRDATA <= 32'h0;
            O_HREADYOUT <= 1'b1;
            O_HRESP <= 1'b0;
        end else if (I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE) begin
            unique case (I_HADDR)
                flow_io_pkg::OFS_INPUT_CFG: O_HRDATA <= in_cfg_reg;
                flow_io_pkg::OFS_THRESHOLD: O_HRDATA <= threshold_reg;
                flow_io_pkg::OFS_RATE_SCALE: O_HRDATA <= rate_scale_reg;
                flow_io_pkg::OFS_TOTAL_SCALE: O_HRDATA <= total_scale_reg;
                flow_io_pkg::OFS_AUX_LOW: O_HRDATA <= aux_low_reg;
                flow_io_pkg::OFS_AUX_HIGH: O_HRDATA <= aux_high_reg;
                flow_io_pkg::OFS_RETX_LOW: O_HRDATA <= retx_low_reg;
                flow_io_pkg::OFS_RETX_HIGH: O_HRDATA <= retx_high_reg;
                flow_io_pkg::OFS_RETX_FAIL: O_HRDATA <= 32'(retx_fail_reg);
                flow_io_pkg::OFS_PULSE_CFG: O_HRDATA <= pulse_cfg_reg;
                flow_io_pkg::OFS_PULSE_VOL: O_HRDATA <= pulse_vol_reg;
                flow_io_pkg::OFS_PULSE_TIME: O_HRDATA <= pulse_time_reg;
                flow_io_pkg::OFS_RELAY_ROUTE: O_HRDATA <= 32'(route_reg);
                flow_io_pkg::OFS_RATE: O_HRDATA <= rate_reg;
                flow_io_pkg::OFS_TOTAL: O_HRDATA <= total_reg;
                flow_io_pkg::OFS_AUX: O_HRDATA <= aux_reg;
                flow_io_pkg::OFS_STATUS: O_HRDATA <= 32'(freq_div_reg);
                default: O_HRDATA <= 32'h0;
            endcase
        end
    end

    // configuration writes; hidden settings ignore writes when unoffered
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            in_cfg_reg <= '0;
            threshold_reg <= 32'h0;
            rate_scale_reg <= 32'h1;
            total_scale_reg <= 32'h1;
            aux_low_reg <= 32'h0;
            aux_high_reg <= 32'h0;
            retx_low_reg <= 32'h0;
            retx_high_reg <= 32'h0;
            retx_fail_reg <= 16'h0;
            pulse_cfg_reg <= '0;
            pulse_vol_reg <= 32'h1;
            pulse_time_reg <= 32'h1;
            freq_div_reg <= 32'h1;
            route_reg <= flow_io_pkg::ROUTE_DEFAULT;
        end else if (wr_pend_reg) begin
            unique case (wr_addr_reg)
                flow_io_pkg::OFS_INPUT_CFG: begin
                    in_cfg_reg <= I_HWDATA;
                    if (I_HWDATA[2:0] > flow_io_pkg::IN_COIL) begin
                        in_cfg_reg.in_type <= in_cfg_reg.in_type;
                    end
                end
                flow_io_pkg::OFS_THRESHOLD: threshold_reg <= I_HWDATA;
                flow_io_pkg::OFS_RATE_SCALE: begin
                    if (!analog_flow) rate_scale_reg <= I_HWDATA;
                end
                flow_io_pkg::OFS_TOTAL_SCALE: total_scale_reg <= I_HWDATA;
                flow_io_pkg::OFS_AUX_LOW: begin
                    if (aux_ok || analog_flow) aux_low_reg <= I_HWDATA;
                end
                flow_io_pkg::OFS_AUX_HIGH: begin
                    if (aux_ok || analog_flow) aux_high_reg <= I_HWDATA;
                end
                flow_io_pkg::OFS_RETX_LOW: retx_low_reg <= I_HWDATA;
                flow_io_pkg::OFS_RETX_HIGH: retx_high_reg <= I_HWDATA;
                flow_io_pkg::OFS_RETX_FAIL: retx_fail_reg <= I_HWDATA[15:0];
                flow_io_pkg::OFS_PULSE_CFG: begin
                    if (I_HWDATA[1:0] != 2'h3) pulse_cfg_reg <= I_HWDATA;
                end
                flow_io_pkg::OFS_PULSE_VOL: pulse_vol_reg <= I_HWDATA;
                flow_io_pkg::OFS_PULSE_TIME: pulse_time_reg <= I_HWDATA;
                flow_io_pkg::OFS_STATUS: freq_div_reg <= I_HWDATA;
                flow_io_pkg::OFS_RELAY_ROUTE: route_reg <= I_HWDATA[11:0];
                flow_io_pkg::OFS_CFG_RESET: route_reg <= flow_io_pkg::ROUTE_DEFAULT;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // input sampling: pin passed through two synchronizer stages, edge from two history bits
    always_ff @(posedge I_MCLK) begin
        if (I_RST) pin_sync_reg <= 3'h0;
        else pin_sync_reg <= {pin_sync_reg[1:0], I_PULSE_IN};
    end
    assign pulse_edge = pin_sync_reg[1] && !pin_sync_reg[2] && !analog_flow;
    // both pin edges, so the frequency divider works for any divider value
    assign pin_change = (pin_sync_reg[1] != pin_sync_reg[2]) && !analog_flow;

    // analog first-order filter, shift set by smoothing
    always_ff @(posedge I_MCLK) begin
        if (I_RST) filt_reg <= 16'h0;
        else if (tick) begin
            if (in_cfg_reg.smoothing == 4'h0 || !(analog_flow || aux_ok))
                filt_reg <= {I_ANALOG, 4'h0};
            else
                filt_reg <= filt_reg + 16'(($signed({1'b0, I_ANALOG, 4'h0})
                    - $signed({1'b0, filt_reg})) >>> in_cfg_reg.smoothing);
        end
    end

    // analog fraction of the 4..20 span, optional square law
    logic [15:0] frac, frac_sq;
    logic [11:0] adc_off;
    logic [31:0] quot;
    always_comb begin
        adc_off = (filt_reg[15:4] > flow_io_pkg::ADC_LOW)
            ? filt_reg[15:4] - flow_io_pkg::ADC_LOW : 12'h0;
        quot = (32'(adc_off) << 16) / 32'(flow_io_pkg::ADC_SPAN);
        // full scale would wrap to zero in 16 bits, so clamp it
        frac = (quot > 32'h0000ffff) ? 16'hffff : quot[15:0];
        frac_sq = 16'((32'(frac) * 32'(frac)) >> 16);
    end

    ////////////////////////////////////////////////////////////////////
    // per-tick rate: pulses counted per tick, scaled to the time base
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            tick_cnt_reg <= 32'h0;
            pulse_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
            pulse_cnt_reg <= tick ? 32'(pulse_edge) : pulse_cnt_reg + 32'(pulse_edge);
        end
    end

    // ticks per time base unit, chosen by the timebase code
    function automatic logic [31:0] per_base(input logic [1:0] tb);
        unique case (tb)
            flow_io_pkg::TB_SEC: per_base = 32'd1000;
            flow_io_pkg::TB_MIN: per_base = 32'd60000;
            flow_io_pkg::TB_HOUR: per_base = 32'd3600000;
            default: per_base = 32'd86400000;
        endcase
    endfunction

    always_comb begin
        if (analog_flow) begin
            // sqrt option applies quadratic law within range
            scaled_next = span(in_cfg_reg.sqrt_en ? frac_sq : frac,
                aux_low_reg, aux_high_reg);
        end else begin
            scaled_next = scale(pulse_cnt_reg,
                per_base(in_cfg_reg.timebase), rate_scale_reg);
        end
        // below threshold reads zero
        rate_next = (scaled_next < threshold_reg) ? 32'h0 : scaled_next;
    end

    // flow units credited per tick, to total and to the pulse volume
    assign flow_add = analog_flow ? 32'h1 : pulse_cnt_reg;
    assign vol_add = (tick && rate_next != 32'h0) ? flow_add : 32'h0;

    // rate and totalizer; total shows the sum including this tick
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            rate_reg <= 32'h0;
            total_acc_reg <= 32'h0;
            total_reg <= 32'h0;
        end else if (tick) begin
            rate_reg <= rate_next;
            if (rate_next != 32'h0) begin
                total_acc_reg <= total_acc_reg + flow_add;
                total_reg <= scale(total_acc_reg + flow_add, 32'h1,
                    total_scale_reg);
            end
        end
    end

    // aux value cleared at once when the aux input is not offered
    always_ff @(posedge I_MCLK) begin
        if (I_RST || !aux_ok) aux_reg <= 32'h0;
        else if (tick)
            aux_reg <= span(frac, aux_low_reg, aux_high_reg);
    end

    ////////////////////////////////////////////////////////////////////
    // retransmission output
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_RETX <= 16'h0;
            O_RETX_EN <= 1'b0;
        end else if (I_IN_FAIL) begin
            O_RETX <= retx_fail_reg;
            O_RETX_EN <= 1'b1;
        end else if (retx_low_reg == retx_high_reg) begin
            O_RETX <= 16'h0;
            O_RETX_EN <= 1'b0;
        end else begin
            O_RETX_EN <= 1'b1;
            if (rate_reg <= retx_low_reg) O_RETX <= flow_io_pkg::DAC_LOW;
            else if (rate_reg >= retx_high_reg) O_RETX <= 16'hffff;
            else O_RETX <= flow_io_pkg::DAC_LOW + 16'(scale(rate_reg - retx_low_reg,
                32'(flow_io_pkg::DAC_SPAN), retx_high_reg - retx_low_reg));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pulse output machine
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            pstate_reg <= flow_io_pkg::PS_IDLE;
            vol_acc_reg <= 32'h0;
            hold_cnt_reg <= 32'h0;
            div_cnt_reg <= 32'h0;
            O_PULSE_OUT <= 1'b0;
        end else begin
            vol_acc_reg <= vol_acc_reg + vol_add;
            unique case (pstate_reg)
                flow_io_pkg::PS_IDLE: begin
                    O_PULSE_OUT <= 1'b0;
                    if (pulse_cfg_reg.mode == flow_io_pkg::PM_FREQ)
                        pstate_reg <= flow_io_pkg::PS_FREQ;
                    else if (pulse_cfg_reg.mode == flow_io_pkg::PM_VOLUME
                             && vol_acc_reg >= pulse_vol_reg) begin
                        // tick credit and pulse debit may land together
                        vol_acc_reg <= vol_acc_reg + vol_add - pulse_vol_reg;
                        hold_cnt_reg <= pulse_time_reg;
                        O_PULSE_OUT <= 1'b1;
                        pstate_reg <= flow_io_pkg::PS_HOLD;
                    end
                end
                flow_io_pkg::PS_HOLD: begin
                    hold_cnt_reg <= hold_cnt_reg - 32'h1;
                    if (hold_cnt_reg <= 32'h1) begin
                        O_PULSE_OUT <= 1'b0;
                        pstate_reg <= flow_io_pkg::PS_IDLE;
                    end
                end
                flow_io_pkg::PS_FREQ: begin
                    if (pulse_cfg_reg.mode != flow_io_pkg::PM_FREQ) begin
                        O_PULSE_OUT <= 1'b0;
                        div_cnt_reg <= 32'h0; // no stale count on re-entry
                        pstate_reg <= flow_io_pkg::PS_IDLE;
                    end else if (pin_change) begin
                        // toggle every div pin changes: out = in / div
                        if (div_cnt_reg + 32'h1 >= freq_div_reg) begin
                            div_cnt_reg <= 32'h0;
                            O_PULSE_OUT <= !O_PULSE_OUT;
                        end else div_cnt_reg <= div_cnt_reg + 32'h1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // relay routing; shared alarms fan out to every routed relay
    always_ff @(posedge I_MCLK) begin
        if (I_RST) O_RELAY <= 4'h0;
        else begin
            for (int r = 0; r < 4; r++) begin
                logic [2:0] sel;
                sel = route_reg[3*r +: 3];
                O_RELAY[r] <= (sel != flow_io_pkg::ROUTE_OFF) && (sel <= 3'h4)
                    && I_ALARM[2'(sel - 3'h1)];
            end
        end
    end

    a_relay_follow: assert property (@(posedge I_MCLK)
        disable iff (I_RST)
        route_reg[2:0] == 3'h2 |=> O_RELAY[0] == $past(I_ALARM[1]))
        else $error("relay one not following alarm");
    a_retx_off: assert property (@(posedge I_MCLK)
        disable iff (I_RST)
        !I_IN_FAIL && retx_low_reg == retx_high_reg |=> !O_RETX_EN)
        else $error("retx on with equal limits");
    a_retx_fail: assert property (@(posedge I_MCLK)
        disable iff (I_RST)
        I_IN_FAIL |=> O_RETX == $past(retx_fail_reg))
        else $error("fail value not applied");
    a_pulse_hold: assert property (@(posedge I_MCLK)
        disable iff (I_RST)
        $rose(O_PULSE_OUT) && pstate_reg == flow_io_pkg::PS_HOLD
        && pulse_time_reg == 32'h5 |-> O_PULSE_OUT [*5] ##1 !O_PULSE_OUT)
        else $error("pulse hold length wrong");
    a_cutoff_zero: assert property (@(posedge I_MCLK)
        disable iff (I_RST)
        tick && scaled_next < threshold_reg |=> rate_reg == 32'h0)
        else $error("cutoff not applied");
    a_total_hold: assert property (@(posedge I_MCLK)
        disable iff (I_RST)
        tick && rate_next == 32'h0 |=> $stable(total_acc_reg))
        else $error("totalized below cutoff");
    a_aux_gate: assert property (@(posedge I_MCLK)
        disable iff (I_RST)
        !aux_ok |=> aux_reg == 32'h0)
        else $error("aux active while not offered");
    a_route_default: assert property (@(posedge I_MCLK)
        $past(I_RST) |-> route_reg == flow_io_pkg::ROUTE_DEFAULT)
        else $error("relay routing not default");
endmodule // flow_io_setup

// *** flow_source.sv ***
////////////////////////////////////////////////////////////////////////
// far side: flow sensor pulses, analog transmitter, alarm levels
module flow_source (
    input wire logic i_clk, // system clock
    output logic o_pulse, // flow pulse train
    output logic [11:0] o_analog, // analog sample
    output logic o_fail, // sensor failure level
    output logic [3:0] o_alarm // alarm levels one..four
);
    timeunit 1ns;
    timeprecision 1ps;

    // quiet sensor at start: line low, transmitter at 4 mA
    initial begin
        o_pulse = 1'b0;
        o_analog = flow_io_pkg::ADC_LOW;
        o_fail = 1'b0;
        o_alarm = 4'h0;
    end

    // line stays low between bursts, as an idle open collector would
    task automatic burst(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge i_clk);
            o_pulse <= 1'b1;
            repeat (half) @(posedge i_clk);
            o_pulse <= 1'b0;
        end
    endtask

    // failure and alarm levels change just after an edge
    task automatic set_state(input logic f, input logic [3:0] a);
        @(posedge i_clk);
        o_fail <= f;
        o_alarm <= a;
    endtask
endmodule // flow_source

// *** testbench.sv ***
////////////////////////////////////////////////////////////////////////
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, rdat, hrdata;
    logic hreadyout, hresp, retx_en, pout, pulse, fail, prev;
    logic [15:0] retx;
    logic [3:0] relay, alarm;
    logic [11:0] analog;
    int err_count = 0, n_tests = 0, rises = 0, hi = 0;

    flow_io_setup DUT (.I_MCLK(clk), .I_RST(rst), .I_HSEL(hsel),
        .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
        .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hreadyout),
        .I_PULSE_IN(pulse), .I_ANALOG(analog), .I_IN_FAIL(fail),
        .I_ALARM(alarm), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
        .O_HRESP(hresp), .O_RETX(retx), .O_RETX_EN(retx_en),
        .O_PULSE_OUT(pout), .O_RELAY(relay));
    flow_source src (.i_clk(clk), .o_pulse(pulse), .o_analog(analog),
        .o_fail(fail), .o_alarm(alarm));

    // 40 MHz clock
    initial forever #12.5 clk = ~clk;

    // count output pulses and their width in cycles
    always @(posedge clk) begin
        prev <= pout;
        if (pout === 1'b1 && prev === 1'b0) rises++;
        if (pout === 1'b1) hi++;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // single word transfer; hready is sampled, never assumed
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdat = hrdata;
    endtask

    task automatic t_regs;
        bus(0, flow_io_pkg::OFS_RELAY_ROUTE, 0);
        chk(rdat, 32'h8d1);
        bus(0, 8'h48, 0);
        chk(rdat | {hresp, 31'h0}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            bus(1, flow_io_pkg::OFS_INPUT_CFG, 32'(i * 17));
            bus(0, flow_io_pkg::OFS_INPUT_CFG, 0);
            chk(rdat[5:0], 32'(i * 17) & 32'h3f);
        end
        bus(1, flow_io_pkg::OFS_INPUT_CFG, 0);
        bus(1, flow_io_pkg::OFS_RATE_SCALE, 5);
        bus(0, flow_io_pkg::OFS_RATE_SCALE, 0);
        chk(rdat, 32'h1);
        bus(1, flow_io_pkg::OFS_INPUT_CFG, 1);
        bus(1, flow_io_pkg::OFS_AUX_LOW, 7);
        bus(0, flow_io_pkg::OFS_AUX_LOW, 0);
        chk(rdat, 32'h0);
        bus(1, flow_io_pkg::OFS_INPUT_CFG, 32'h9);
        bus(1, flow_io_pkg::OFS_AUX_LOW, 7);
        bus(0, flow_io_pkg::OFS_AUX_LOW, 0);
        chk(rdat, 32'h7);
        bus(1, flow_io_pkg::OFS_INPUT_CFG, 32'hd);
        bus(0, flow_io_pkg::OFS_INPUT_CFG, 0);
        chk(rdat[2:0], 32'h1);
        $display("test regs done");
    endtask

    task automatic t_relay;
        bus(1, flow_io_pkg::OFS_RELAY_ROUTE, 32'h812);
        src.set_state(1'b0, 4'b1010);
        repeat (3) @(posedge clk);
        chk(relay, 4'b1011);
        src.set_state(1'b0, 4'b0100);
        repeat (3) @(posedge clk);
        chk(relay, 4'b0000);
        bus(1, flow_io_pkg::OFS_CFG_RESET, 0);
        src.set_state(1'b0, 4'b1010);
        repeat (3) @(posedge clk);
        chk(relay, 4'b1010);
        src.set_state(1'b0, 4'b0000);
        $display("test relay done");
    endtask

    task automatic t_retx;
        bus(1, flow_io_pkg::OFS_RETX_LOW, 5);
        bus(1, flow_io_pkg::OFS_RETX_HIGH, 5);
        repeat (3) @(posedge clk);
        chk(retx_en, 1'b0);
        bus(1, flow_io_pkg::OFS_RETX_FAIL, 32'h1234);
        src.set_state(1'b1, 4'h0);
        repeat (3) @(posedge clk);
        chk({retx_en, retx}, 17'h11234);
        src.set_state(1'b0, 4'h0);
        bus(1, flow_io_pkg::OFS_RETX_LOW, 0);
        bus(1, flow_io_pkg::OFS_RETX_HIGH, 100);
        repeat (3) @(posedge clk);
        chk({retx_en, retx}, {1'b1, flow_io_pkg::DAC_LOW});
        $display("test retx done");
    endtask

    task automatic t_pulse;
        bus(1, flow_io_pkg::OFS_TOTAL_SCALE, 2);
        bus(1, flow_io_pkg::OFS_PULSE_VOL, 3);
        bus(1, flow_io_pkg::OFS_PULSE_TIME, 5);
        bus(1, flow_io_pkg::OFS_PULSE_CFG, flow_io_pkg::PM_VOLUME);
        rises = 0;
        hi = 0;
        src.burst(6, 20);
        // pulses are credited only at the next 1 ms tick
        repeat (flow_io_pkg::TICK_CYC + 100) @(posedge clk);
        chk(rises, 2);
        chk(hi, 10);
        bus(1, 8'h40, 2);
        bus(1, flow_io_pkg::OFS_PULSE_CFG, flow_io_pkg::PM_FREQ);
        rises = 0;
        src.burst(8, 20);
        repeat (10) @(posedge clk);
        chk(rises, 4);
        bus(1, flow_io_pkg::OFS_PULSE_CFG, 3);
        bus(0, flow_io_pkg::OFS_PULSE_CFG, 0);
        chk(rdat[1:0], flow_io_pkg::PM_FREQ);
        bus(1, flow_io_pkg::OFS_PULSE_CFG, flow_io_pkg::PM_OFF);
        rises = 0;
        src.burst(4, 20);
        repeat (10) @(posedge clk);
        chk(rises, 0);
        $display("test pulse done");
    endtask

    // one full measurement tick of pulses all below the cutoff
    task automatic t_cutoff;
        // 6 pulses in one 1 ms tick: 6000 per second, total 6 / 2
        bus(0, flow_io_pkg::OFS_RATE, 0);
        chk(rdat, 32'h1770);
        bus(0, flow_io_pkg::OFS_TOTAL, 0);
        chk(rdat, 32'h3);
        bus(1, flow_io_pkg::OFS_THRESHOLD, 32'hffffffff);
        src.burst(2100, 10);
        repeat (10) @(posedge clk);
        bus(0, flow_io_pkg::OFS_RATE, 0);
        chk(rdat, 32'h0);
        bus(0, flow_io_pkg::OFS_TOTAL, 0);
        chk(rdat, 32'h3);
        $display("test cutoff done");
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_relay;
        t_retx;
        t_pulse;
        t_cutoff;
        stop_test;
    end

    // all tests need about 83000 cycles; allow 95000
    initial begin
        #2375000;
        err_count++;
        stop_test;
    end
endmodule // testbench
